// file: common/sap_defs.svh
`ifndef SAP_DEFS_SVH
`define SAP_DEFS_SVH
// Register byte offsets.
`define SAP_TX_CSR   8'h00
`define SAP_RX_CSR   8'h04
`define SAP_CLK_CFG  8'h08
`define SAP_FRM_CFG  8'h0C
`define SAP_WID_CFG  8'h10
`define SAP_WMARK    8'h14
`define SAP_TX_PTR   8'h18
`define SAP_RX_PTR   8'h1C
`define SAP_TX_DATA0 8'h20
`define SAP_TX_DATA1 8'h24
`define SAP_RX_DATA0 8'h28
`define SAP_RX_DATA1 8'h2C
`define SAP_MCLK_CR  8'h30
`define SAP_MCLK_DR  8'h34
// Flag positions inside each control/status register.
`define SAP_BIT_REQ   16
`define SAP_BIT_WARN  17
`define SAP_BIT_FAULT 18
`define SAP_BIT_SYNC  19
`define SAP_BIT_WORD  20
// Master clock control fields.
`define SAP_MCR_SRC 0
`define SAP_MCR_OE  1
`define SAP_MCR_UPD 2
// FIFO depth in words.
`define SAP_FIFO_DEPTH 16
// Writable bits of each configuration register; the rest read back as zero, except flag bits 16..20 of the control/status registers.
`define SAP_CSR_MASK 32'hB000_1F03
`define SAP_CLK_MASK 32'h0000_1FFF
`define SAP_FRM_MASK 32'h1F1F_3FFF
`define SAP_WID_MASK 32'h0000_1F1F
// Master clock divider reset values.
`define SAP_MDR_MASTER_DIVIDER_FRACTION_RST 8'h01
`define SAP_MDR_DIV_RST   8'h02
`endif

// file: common/sap_pkg.sv
package sap_pkg;
   // Frame engine state.
   typedef enum logic {SAP_IDLE = 1'b0, SAP_RUN = 1'b1} sap_state_type;
   // Per-direction control word.
   typedef struct packed {
      logic       enable;
      logic       rsv_a;
      logic [1:0] chan_en;
      logic [14:0] rsv_b;
      logic       word_start_irq_en;
      logic       sync_error_irq_en;
      logic       fifo_fault_irq_en;
      logic       fifo_warning_irq_en;
      logic       fifo_request_irq_en;
      logic [5:0] rsv_c;
      logic       fifo_warning_dma_en;
      logic       fifo_request_dma_en;
   } sap_csr_type;
   // Bit clock configuration.
   typedef struct packed {
      logic [18:0] rsv;
      logic       master_clock_choice;
      logic       bitclk_input_select;
      logic       bitclk_swap;
      logic       bitclk_direction;
      logic       bitclk_polarity;
      logic [7:0] bitclk_divider;
   } sap_clk_type;
   // Frame and frame sync configuration.
   typedef struct packed {
      logic [2:0] rsv_a;
      logic [4:0] word_start_select;
      logic [2:0] rsv_b;
      logic [4:0] first_bit_index;
      logic [1:0] rsv_c;
      logic       msb_first;
      logic       sync_direction;
      logic       sync_polarity;
      logic       sync_early;
      logic [4:0] sync_length;
      logic [4:0] words_per_frame;
   } sap_frame_type;
   // Word widths, stored as width minus one.
   typedef struct packed {
      logic [18:0] rsv_a;
      logic [4:0] later_word_width;
      logic [2:0] rsv_b;
      logic [4:0] first_word_width;
   } sap_width_type;
endpackage

// file: hdl/sap_port.sv
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "sap_defs.svh"
module sap_port #(
   parameter int DEPTH = `SAP_FIFO_DEPTH   // Words per FIFO.
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WR_DATA,
   input  wire logic        WR_STB,
   input  wire logic        RD_STB,
   output logic      [31:0] RD_DATA,
   input  wire logic        BCLK_IN,
   output logic             BCLK_OUT,
   output logic             BCLK_OE,
   input  wire logic        FS_IN,
   output logic             FS_OUT,
   output logic             FS_OE,
   input  wire logic        MCLK_IN,
   output logic             MCLK_OUT,
   output logic             MCLK_OE,
   output logic      [1:0]  TXD,
   input  wire logic [1:0]  RXD,
   output logic             TX_IRQ,
   output logic             RX_IRQ,
   output logic             TX_DMA,
   output logic             RX_DMA
);
   localparam int AW = $clog2(DEPTH);
   // =====================================================
   // Register storage
   sap_pkg::sap_csr_type   tx_csr, rx_csr;     // Direction controls.
   sap_pkg::sap_clk_type   clk_cfg;            // Bit clock setup.
   sap_pkg::sap_frame_type frm;                // Frame setup.
   sap_pkg::sap_width_type wid;                // Word widths.
   logic [AW:0]  tx_watermark, rx_watermark;   // Watermarks.
   logic         master_source_select;         // External source.
   logic         master_clock_out_en;          // Drive master clock pin.
   logic [7:0]   master_divider_fraction;      // Added per source tick.
   logic [7:0]   master_divider;               // Wrap value.
   logic         divider_update_pending;       // Divider change not yet used.
   logic [4:0]   tx_flag, rx_flag;             // Sticky and live flags.
   // Address decode.
   wire wr_hit_tx  = WR_STB && ADDR == `SAP_TX_CSR;
   wire wr_hit_rx  = WR_STB && ADDR == `SAP_RX_CSR;
   wire wr_hit_mdr = WR_STB && ADDR == `SAP_MCLK_DR;
   wire [1:0] tx_push = {WR_STB && ADDR == `SAP_TX_DATA1, WR_STB && ADDR == `SAP_TX_DATA0};
   wire [1:0] rx_pop_req = {RD_STB && ADDR == `SAP_RX_DATA1, RD_STB && ADDR == `SAP_RX_DATA0};
   // Software-written configuration; reserved bits are dropped, flags are handled further down.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         tx_csr <= '0;
         rx_csr <= '0;
         clk_cfg <= '0;
         frm <= '0;
         wid <= '0;
         tx_watermark <= '0;
         rx_watermark <= '0;
         master_source_select <= 1'b0;
         master_clock_out_en <= 1'b0;
         master_divider_fraction <= `SAP_MDR_MASTER_DIVIDER_FRACTION_RST;
         master_divider <= `SAP_MDR_DIV_RST;
      end else if (WR_STB) begin
         if (wr_hit_tx) tx_csr <= sap_pkg::sap_csr_type'(WR_DATA & `SAP_CSR_MASK);
         if (wr_hit_rx) rx_csr <= sap_pkg::sap_csr_type'(WR_DATA & `SAP_CSR_MASK);
         if (ADDR == `SAP_CLK_CFG) clk_cfg <= sap_pkg::sap_clk_type'(WR_DATA & `SAP_CLK_MASK);
         if (ADDR == `SAP_FRM_CFG) frm <= sap_pkg::sap_frame_type'(WR_DATA & `SAP_FRM_MASK);
         if (ADDR == `SAP_WID_CFG) wid <= sap_pkg::sap_width_type'(WR_DATA & `SAP_WID_MASK);
         if (ADDR == `SAP_WMARK) begin
            tx_watermark <= WR_DATA[AW:0];
            rx_watermark <= WR_DATA[AW+8:8];
         end
         if (ADDR == `SAP_MCLK_CR) begin
            master_source_select <= WR_DATA[`SAP_MCR_SRC];
            master_clock_out_en  <= WR_DATA[`SAP_MCR_OE];
         end
         if (wr_hit_mdr) begin
            master_divider_fraction <= WR_DATA[7:0];
            master_divider <= WR_DATA[15:8];
         end
      end
   end
   // =====================================================
   // Input synchronisers: pins pass two flops, edges from stage two on.
   logic [4:0] pin_s1, pin_s2, pin_s3;
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end else begin
         pin_s1 <= {MCLK_IN, FS_IN, BCLK_IN, RXD};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end
   wire [1:0] rxd_s = pin_s2[1:0];
   wire ext_mclk_edge = pin_s2[4] & ~pin_s3[4];
   // =====================================================
   // Master clock: fractional accumulator toggles the master clock.
   logic [8:0] mclk_acc;                          // Fraction accumulator.
   wire src_tick = master_source_select ? ext_mclk_edge : 1'b1;
   wire [8:0] acc_sum = mclk_acc + {1'b0, master_divider_fraction};
   wire mclk_wrap = src_tick && acc_sum >= {1'b0, master_divider};
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         mclk_acc <= '0;
         MCLK_OUT <= 1'b0;
         MCLK_OE <= 1'b0;
         divider_update_pending <= 1'b0;
      end else begin
         MCLK_OE <= master_clock_out_en;
         if (src_tick) mclk_acc <= mclk_wrap ? acc_sum - {1'b0, master_divider} : acc_sum;
         if (mclk_wrap) MCLK_OUT <= ~MCLK_OUT;
         // A new write wins over the clearing edge.
         if (wr_hit_mdr) divider_update_pending <= 1'b1;
         else if (mclk_wrap) divider_update_pending <= 1'b0;
      end
   end
   // =====================================================
   // Bit clock: prescaler on the system clock or, with master_clock_choice set, the master clock; or a pin input.
   logic [7:0] bclk_cnt;                          // Prescaler count.
   logic       bclk_int;                          // Internal bit clock.
   wire mtick = clk_cfg.master_clock_choice ? mclk_wrap : 1'b1;
   wire run_en = tx_csr.enable | rx_csr.enable;
   wire bclk_tog = run_en && mtick && bclk_cnt == clk_cfg.bitclk_divider;
   wire int_rise = bclk_tog & ~bclk_int;
   wire int_fall = bclk_tog & bclk_int;
   wire ext_rise = pin_s2[2] & ~pin_s3[2];
   wire ext_fall = ~pin_s2[2] & pin_s3[2];
   wire use_ext = ~clk_cfg.bitclk_direction | clk_cfg.bitclk_input_select;
   wire b_rise = use_ext ? ext_rise : int_rise;
   wire b_fall = use_ext ? ext_fall : int_fall;
   // Polarity picks the drive edge; swap exchanges drive and sample edges.
   wire edge_sel = clk_cfg.bitclk_polarity ^ clk_cfg.bitclk_swap;
   wire drv_ev = edge_sel ? b_rise : b_fall;
   wire smp_ev = edge_sel ? b_fall : b_rise;
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         bclk_cnt <= '0;
         bclk_int <= 1'b0;
         BCLK_OUT <= 1'b0;
         BCLK_OE <= 1'b0;
      end else begin
         if (mtick) bclk_cnt <= bclk_tog ? 8'h00 : bclk_cnt + 8'h01;
         if (bclk_tog) bclk_int <= ~bclk_int;
         BCLK_OUT <= bclk_int;
         BCLK_OE <= clk_cfg.bitclk_direction;
      end
   end
   // =====================================================
   // Frame sequencing shared by both lines.
   sap_pkg::sap_state_type state;
   logic [4:0] word_cnt, bit_cnt;                 // Position in frame.
   logic [5:0] fs_bits;                           // Bits since frame start.
   logic       fs_prev, sync_seen;                // Sync edge detection.
   wire fs_in_act = pin_s2[3] ^ frm.sync_polarity;
   wire [4:0] cur_w = word_cnt == 5'h00 ? wid.first_word_width : wid.later_word_width;
   wire last_bit = bit_cnt == cur_w;
   wire eof = last_bit && word_cnt == frm.words_per_frame;
   wire run = state == sap_pkg::SAP_RUN;
   // Master sync restarts at frame end; slave sync waits for the sync edge.
   wire restart = frm.sync_direction ? (!run || eof) : sync_seen;
   wire [4:0] next_word = restart ? 5'h00 : (last_bit ? word_cnt + 5'h01 : word_cnt);
   wire [4:0] next_bit = (restart || last_bit) ? 5'h00 : bit_cnt + 5'h01;
   wire word_begin = drv_ev && (restart || (run && last_bit && !eof));
   wire [4:0] next_idx = frm.msb_first ? frm.first_bit_index - next_bit
                                       : frm.first_bit_index + next_bit;
   wire [4:0] cur_idx = frm.msb_first ? frm.first_bit_index - bit_cnt
                                      : frm.first_bit_index + bit_cnt;
   wire [5:0] next_fs = restart ? 6'h00 : (fs_bits == 6'h3F ? fs_bits : fs_bits + 6'h01);
   wire next_eof = !restart && next_bit == cur_w && next_word == frm.words_per_frame;
   wire fs_level = frm.sync_early ? (next_eof || next_fs < {1'b0, frm.sync_length})
                                  : next_fs <= {1'b0, frm.sync_length};
   // A sync edge in mid-frame means the frame alignment was lost.
   wire sync_lost = smp_ev && fs_in_act && !fs_prev && !frm.sync_direction && run && !eof;
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         state <= sap_pkg::SAP_IDLE;
         word_cnt <= '0;
         bit_cnt <= '0;
         fs_bits <= '0;
         fs_prev <= 1'b0;
         sync_seen <= 1'b0;
         FS_OUT <= 1'b0;
         FS_OE <= 1'b0;
      end else begin
         FS_OE <= frm.sync_direction;
         if (smp_ev) fs_prev <= fs_in_act;
         if (smp_ev && fs_in_act && !fs_prev) sync_seen <= 1'b1;
         else if (drv_ev) sync_seen <= 1'b0;
         if (!run_en) begin
            state <= sap_pkg::SAP_IDLE;
            FS_OUT <= frm.sync_polarity;
         end else if (drv_ev) begin
            if (restart) state <= sap_pkg::SAP_RUN;
            else if (eof) state <= sap_pkg::SAP_IDLE;
            word_cnt <= next_word;
            bit_cnt <= next_bit;
            fs_bits <= next_fs;
            FS_OUT <= (fs_level & (restart || run)) ^ frm.sync_polarity;
         end
      end
   end
   // =====================================================
   // Per-line FIFOs with wrap-bit pointers.
   logic [AW:0] tx_wp [2];                        // TX write pointers.
   logic [AW:0] tx_rp [2];                        // TX read pointers.
   logic [AW:0] rx_wp [2];                        // RX write pointers.
   logic [AW:0] rx_rp [2];                        // RX read pointers.
   logic [31:0] rx_q [2];                         // RX read-out words.
   wire  [1:0]  tx_req, tx_empty, rx_req, rx_full, under, over;
   logic [1:0]  tx_act, rx_act;
   assign tx_act = tx_csr.enable ? tx_csr.chan_en : 2'b00;
   assign rx_act = rx_csr.enable ? rx_csr.chan_en : 2'b00;
   for (genvar c = 0; c < 2; c++) begin : g_line
      logic [31:0] tx_mem [DEPTH];               // TX storage.
      logic [31:0] rx_mem [DEPTH];               // RX storage.
      logic [31:0] tx_sh, rx_sh;                 // Shift words.
      wire [AW:0] tx_lvl = tx_wp[c] - tx_rp[c];
      wire [AW:0] rx_lvl = rx_wp[c] - rx_rp[c];
      wire t_empty = tx_wp[c] == tx_rp[c];
      wire t_full = tx_wp[c] == {~tx_rp[c][AW], tx_rp[c][AW-1:0]};
      wire r_empty = rx_wp[c] == rx_rp[c];
      wire r_full = rx_wp[c] == {~rx_rp[c][AW], rx_rp[c][AW-1:0]};
      wire load = word_begin && tx_act[c];
      wire [31:0] tx_src = t_empty ? 32'h0000_0000 : tx_mem[tx_rp[c][AW-1:0]];
      logic [31:0] rx_nxt;
      always_comb begin
         rx_nxt = bit_cnt == 5'h00 ? 32'h0000_0000 : rx_sh;
         rx_nxt[cur_idx] = rxd_s[c];
      end
      wire push = smp_ev && run && last_bit && rx_act[c];
      assign tx_req[c] = tx_act[c] && tx_lvl < tx_watermark;
      assign rx_req[c] = rx_act[c] && rx_lvl > rx_watermark;
      assign tx_empty[c] = tx_act[c] && t_empty;
      assign rx_full[c] = rx_act[c] && r_full;
      assign under[c] = load && t_empty;
      assign over[c] = push && r_full;
      // Pointer, memory and shift updates for this line.
      always_ff @(posedge CLK) begin
         if (!RSTN) begin
            tx_wp[c] <= '0;
            tx_rp[c] <= '0;
            rx_wp[c] <= '0;
            rx_rp[c] <= '0;
            tx_sh <= '0;
            rx_sh <= '0;
            rx_q[c] <= '0;
            TXD[c] <= 1'b0;
         end else begin
            if (tx_push[c] && !t_full) begin
               tx_mem[tx_wp[c][AW-1:0]] <= WR_DATA;
               tx_wp[c] <= tx_wp[c] + (AW+1)'(1);
            end
            if (load) tx_sh <= tx_src;
            if (load && !t_empty) tx_rp[c] <= tx_rp[c] + (AW+1)'(1);
            if (drv_ev) TXD[c] <= tx_act[c] && (load ? tx_src[next_idx] : tx_sh[next_idx]);
            if (smp_ev && run) rx_sh <= rx_nxt;
            if (push && !r_full) begin
               rx_mem[rx_wp[c][AW-1:0]] <= rx_nxt;
               rx_wp[c] <= rx_wp[c] + (AW+1)'(1);
            end
            rx_q[c] <= rx_mem[rx_rp[c][AW-1:0]];
            if (rx_pop_req[c] && !r_empty) rx_rp[c] <= rx_rp[c] + (AW+1)'(1);
         end
      end
   end
   // =====================================================
   // Flags: bits 0,1 live (request, warning); 2..4 sticky, write one to clear.
   wire ws_ev = word_begin && next_word == frm.word_start_select;
   wire [2:0] tx_set = {ws_ev & tx_csr.enable, sync_lost & tx_csr.enable, |under};
   wire [2:0] rx_set = {ws_ev & rx_csr.enable, sync_lost & rx_csr.enable, |over};
   wire [2:0] tx_clr = wr_hit_tx ? WR_DATA[`SAP_BIT_WORD:`SAP_BIT_FAULT] : 3'b000;
   wire [2:0] rx_clr = wr_hit_rx ? WR_DATA[`SAP_BIT_WORD:`SAP_BIT_FAULT] : 3'b000;
   // Interrupt and DMA gating per direction.
   wire next_tx_irq = |(tx_flag & {tx_csr.word_start_irq_en, tx_csr.sync_error_irq_en,
                   tx_csr.fifo_fault_irq_en, tx_csr.fifo_warning_irq_en, tx_csr.fifo_request_irq_en});
   wire next_rx_irq = |(rx_flag & {rx_csr.word_start_irq_en, rx_csr.sync_error_irq_en,
                   rx_csr.fifo_fault_irq_en, rx_csr.fifo_warning_irq_en, rx_csr.fifo_request_irq_en});
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         tx_flag <= '0;
         rx_flag <= '0;
         TX_IRQ <= 1'b0;
         RX_IRQ <= 1'b0;
         TX_DMA <= 1'b0;
         RX_DMA <= 1'b0;
      end else begin
         tx_flag[1:0] <= {|tx_empty, |tx_req};
         rx_flag[1:0] <= {|rx_full, |rx_req};
         // Set wins over a clear in the same cycle.
         tx_flag[4:2] <= tx_set | (tx_flag[4:2] & ~tx_clr);
         rx_flag[4:2] <= rx_set | (rx_flag[4:2] & ~rx_clr);
         TX_IRQ <= next_tx_irq;
         RX_IRQ <= next_rx_irq;
         TX_DMA <= (tx_flag[0] & tx_csr.fifo_request_dma_en) |
                   (tx_flag[1] & tx_csr.fifo_warning_dma_en);
         RX_DMA <= (rx_flag[0] & rx_csr.fifo_request_dma_en) |
                   (rx_flag[1] & rx_csr.fifo_warning_dma_en);
      end
   end
   // =====================================================
   // Read path: data appear the cycle after the read strobe.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (ADDR)
         `SAP_TX_CSR:   rd_mux = tx_csr | {11'h000, tx_flag, 16'h0000};
         `SAP_RX_CSR:   rd_mux = rx_csr | {11'h000, rx_flag, 16'h0000};
         `SAP_CLK_CFG:  rd_mux = clk_cfg;
         `SAP_FRM_CFG:  rd_mux = frm;
         `SAP_WID_CFG:  rd_mux = wid;
         `SAP_WMARK:    rd_mux = {16'h0000, 8'(rx_watermark), 8'(tx_watermark)};
         `SAP_TX_PTR:   rd_mux = {8'(tx_rp[1]), 8'(tx_wp[1]), 8'(tx_rp[0]), 8'(tx_wp[0])};
         `SAP_RX_PTR:   rd_mux = {8'(rx_rp[1]), 8'(rx_wp[1]), 8'(rx_rp[0]), 8'(rx_wp[0])};
         `SAP_RX_DATA0: rd_mux = rx_q[0];
         `SAP_RX_DATA1: rd_mux = rx_q[1];
         `SAP_MCLK_CR:  rd_mux = {29'h0, divider_update_pending, master_clock_out_en,
                                  master_source_select};
         `SAP_MCLK_DR:  rd_mux = {16'h0000, master_divider, master_divider_fraction};
         default:       rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge CLK) begin
      if (!RSTN) RD_DATA <= '0;
      else RD_DATA <= RD_STB ? rd_mux : 32'h0000_0000;
   end
endmodule // sap_port

// file: sim/sap_port_sva.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the serial audio port.
module sap_port_sva (
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic        WR_STB,
   input wire logic        RD_STB,
   input wire logic [31:0] RD_DATA,
   input wire logic        BCLK_OE,
   input wire logic        FS_OE,
   input wire logic        MCLK_OE,
   input wire logic        TX_IRQ,
   input wire logic        TX_DMA
);
   logic [31:0] tx_csr;  // Copy of the last transmit control write.
   logic [12:0] width;   // Copy of the last width write.
   // The copies follow software writes so gating and width readback can be judged.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         tx_csr <= 32'h0;
         width  <= 13'h0;
      end else if (WR_STB && ADDR == 8'h00) begin
         tx_csr <= WR_DATA;
      end else if (WR_STB && ADDR == 8'h10) begin
         width <= WR_DATA[12:0];
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   a_reset_quiet: assert property (!$past(RSTN) |-> !TX_IRQ && !TX_DMA && !FS_OE && !BCLK_OE)
      else $error("outputs active right after reset");
   a_read_idle: assert property (!RD_STB |=> RD_DATA == 32'h0)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (RD_STB && ADDR > 8'h34 |=> RD_DATA == 32'h0)
      else $error("unmapped read not zero");
   a_width_back: assert property (RD_STB && ADDR == 8'h10 |=> RD_DATA == {19'h0, width[12:8], 3'h0, width[4:0]})
      else $error("width readback wrong");
   a_sync_drive: assert property (WR_STB && ADDR == 8'h0C && WR_DATA[12] |-> ##2 FS_OE)
      else $error("frame sync not driven");
   a_bclk_drive: assert property (WR_STB && ADDR == 8'h08 && WR_DATA[9] |-> ##2 BCLK_OE)
      else $error("bit clock not driven");
   a_mclk_drive: assert property (WR_STB && ADDR == 8'h30 && WR_DATA[1] |-> ##2 MCLK_OE)
      else $error("master clock not driven");
   a_dma_gate: assert property ((tx_csr[1:0] == 2'h0)[*3] |-> !TX_DMA)
      else $error("dma request while disabled");
   a_irq_gate: assert property ((tx_csr[12:8] == 5'h0)[*3] |-> !TX_IRQ)
      else $error("interrupt while disabled");
endmodule // sap_port_sva
bind sap_port sap_port_sva u_sva (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
   .RD_STB(RD_STB), .RD_DATA(RD_DATA), .BCLK_OE(BCLK_OE), .FS_OE(FS_OE), .MCLK_OE(MCLK_OE),
   .TX_IRQ(TX_IRQ), .TX_DMA(TX_DMA));

// file: sim/sap_codec_model.sv
`timescale 1ns/1ps
// ==========================================
// Peer port that echoes both data lines back.
module sap_codec_model (
   input wire logic       CLK,
   input wire logic [1:0] TXD,
   output logic     [1:0] RXD
);
   // One system clock of delay stays well inside half a bit period.
   always @(posedge CLK) begin
      RXD <= TXD;
   end
endmodule // sap_codec_model

// file: sim/testbench.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the serial audio port.
module testbench;
   logic        CLK = 1'b0;
   logic        RSTN = 1'b0;
   logic [7:0]  ADDR = 8'h00;
   logic [31:0] WR_DATA = 32'h0;
   logic        WR_STB = 1'b0;
   logic        RD_STB = 1'b0;
   logic [31:0] RD_DATA;
   logic [1:0]  TXD;
   logic [1:0]  RXD;
   logic        TX_IRQ;
   logic        RX_IRQ;
   logic        TX_DMA;
   logic        RX_DMA;
   logic        BCLK_OUT;
   logic        FS_OUT;
   logic        MCLK_OUT;
   int          rises;
   int          highs;
   int          num_errors = 0;
   int          check_count = 0;
   int          seed = 74020;
   logic [31:0] rd_val;
   logic [31:0] exp_q[2][$];
   always #4 CLK = ~CLK;
   sap_port dut (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
      .RD_DATA(RD_DATA), .BCLK_IN(1'b0), .BCLK_OUT(BCLK_OUT), .BCLK_OE(), .FS_IN(1'b0), .FS_OUT(FS_OUT),
      .FS_OE(), .MCLK_IN(1'b0), .MCLK_OUT(MCLK_OUT), .MCLK_OE(), .TXD(TXD), .RXD(RXD), .TX_IRQ(TX_IRQ),
      .RX_IRQ(RX_IRQ),
      .TX_DMA(TX_DMA), .RX_DMA(RX_DMA));
   sap_codec_model codec (.CLK(CLK), .TXD(TXD), .RXD(RXD));
   // Register write: one cycle strobe.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      WR_DATA <= d;
      WR_STB <= 1'b1;
      @(posedge CLK);
      WR_STB <= 1'b0;
   endtask
   // Register read: data is taken in the cycle after the strobe.
   task automatic rd(input logic [7:0] a);
      @(posedge CLK);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge CLK);
      RD_STB <= 1'b0;
      #1 rd_val = RD_DATA;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Pointer word expected for given write and read counts.
   function automatic logic [31:0] ptrs(input int w0, input int r0, input int w1, input int r1);
      return {3'h0, 5'(r1), 3'h0, 5'(w1), 3'h0, 5'(r0), 3'h0, 5'(w0)};
   endfunction
   // Counts rising edges and high samples of one clock-like pin over a window of cycles.
   task automatic count_pin(input int sel, input int cycles, output int n_rise, output int n_high);
      logic cur;
      logic prev;
      n_rise = 0;
      n_high = 0;
      prev = 1'b0;
      for (int i = 0; i <= cycles; i++) begin
         @(posedge CLK);
         cur = sel == 0 ? BCLK_OUT : (sel == 1 ? FS_OUT : MCLK_OUT);
         if (i > 0 && cur && !prev) n_rise++;
         if (i > 0 && cur) n_high++;
         prev = cur;
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Hang guard.
   initial begin
      #400000;
      num_errors++;
      wrap_up();
   end
   initial begin
      int n;
      logic [31:0] w;
      repeat (16) @(posedge CLK);
      RSTN <= 1'b1;
      rd(8'h00); cmp("tx_csr reset", 32'h0000_0000, rd_val);
      rd(8'h34); cmp("mdr reset", 32'h0000_0201, rd_val);
      wr(8'h40, $random(seed));
      rd(8'h40); cmp("unmapped", 32'h0, rd_val);
      $display("test reset done");
      wr(8'h14, 32'h0000_0004);
      // Flags of lines that are not yet enabled stay low.
      rd(8'h00); cmp("tx flags empty", 32'h0, {30'h0, rd_val[17:16]});
      // Line 0 gets a burst one word past its depth, line 1 a burst below depth minus watermark.
      for (n = 0; n < 20; n++) begin
         w = ($random(seed) & 32'hFFFF) | 32'h1;
         if (n < 17) wr(8'h20, w);
         if (n < 16) exp_q[0].push_back(w);
         if (n < 3) begin
            wr(8'h24, w ^ 32'h8000);
            exp_q[1].push_back(w ^ 32'h8000);
         end
      end
      rd(8'h18); cmp("tx ptr full", ptrs(16, 0, 3, 0), rd_val);
      rd(8'h00); cmp("tx flags full", 32'h0, {30'h0, rd_val[17:16]});
      $display("test fill done");
      wr(8'h08, 32'h0000_0203);
      wr(8'h0C, 32'h000F_3001);
      wr(8'h10, 32'h0000_0F0F);
      rd(8'h10); cmp("width", 32'h0000_0F0F, rd_val);
      wr(8'h30, 32'h0000_0002);
      wr(8'h04, 32'hB000_0000);
      wr(8'h00, 32'hB000_0401);
      for (n = 0; n < 4000 && exp_q[0].size() + exp_q[1].size() > 0; n++) begin
         rd(8'h1C);
         w = rd_val;
         for (int l = 0; l < 2; l++) begin
            if (w[16*l +: 5] != w[16*l+8 +: 5]) begin
               rd(l ? 8'h2C : 8'h28);
               if (rd_val !== 32'h0) cmp("rx word", exp_q[l].size() ? exp_q[l].pop_front() : 32'hX, rd_val);
            end
         end
      end
      if (exp_q[0].size() + exp_q[1].size() > 0) num_errors++;
      repeat (300) @(posedge CLK);
      rd(8'h18); cmp("tx ptr drained", ptrs(16, 16, 3, 3), rd_val);
      rd(8'h00); cmp("tx flags end", 32'h17, {27'h0, rd_val[20:16]});
      cmp("tx irq", 32'h1, {31'h0, TX_IRQ});
      cmp("tx dma", 32'h1, {31'h0, TX_DMA});
      cmp("rx irq", 32'h0, {31'h0, RX_IRQ});
      cmp("rx dma", 32'h0, {31'h0, RX_DMA});
      // Bit clock period is 8 cycles, one-bit sync in a 32-bit frame, master clock period 4.
      count_pin(0, 80, rises, highs); cmp("bclk rises", 32'h0000_000A, rises);
      count_pin(1, 256, rises, highs); cmp("fs high cycles", 32'h0000_0008, highs);
      count_pin(2, 80, rises, highs); cmp("mclk rises", 32'h0000_0014, rises);
      // Prescaler ticks on the master clock: bit clock period becomes 16 cycles.
      wr(8'h08, 32'h0000_1203);
      repeat (40) @(posedge CLK);
      count_pin(0, 80, rises, highs); cmp("bclk from mclk", 32'h0000_0005, rises);
      $display("test stream done");
      wrap_up();
   end
endmodule // testbench
